// file: low_power_monitoring_hb_regs.vh
// Register map, field positions, reset values and timing for the heartbeat relay
`ifndef HEARTBEAT_RELAY_REGS_VH
`define HEARTBEAT_RELAY_REGS_VH

`define ADDR_CTRL 4'h0
`define ADDR_NDEV 4'h1
`define ADDR_CELL_UV 4'h2
`define ADDR_CELL_OV 4'h3
`define ADDR_CELL_DV 4'h4
`define ADDR_AUX_UV 4'h5
`define ADDR_AUX_OV 4'h6
`define ADDR_AUX_DV 4'h7
`define ADDR_CELL_MASK 4'h8
`define ADDR_AUX_MASK 4'h9
`define ADDR_FLAGS 4'hA
`define ADDR_STATUS 4'hB

`define CTRL_EN_BIT 0
`define CTRL_MGR_BIT 1

`define FLAG_CELL_UNDER 0
`define FLAG_CELL_OVER 1
`define FLAG_CELL_FALL 2
`define FLAG_CELL_RISE 3
`define FLAG_AUX_UNDER 4
`define FLAG_AUX_OVER 5
`define FLAG_AUX_FALL 6
`define FLAG_AUX_RISE 7

`define NDEV_RST 8'h42
`define COUNT_OFFSET 8'h42
`define UV_RST 16'h0000
`define OV_RST 16'hFFFF
`define DV_RST 16'hFFFF
`define FLAGS_ALL 8'hFF
`define FLAGS_NONE 8'h00
`define CLEAR_KEY 16'hFFFF

`define FRAME_BYTES 8
`define LAST_BYTE 3'h7
`define CLK_MHZ 200
`define START_DELAY_US 31000
`define MIN_RELAY_US 5000
`define PERIOD_US 1000000

`endif

// file: prev_sample_mem.v
// Previous-sample store, one word per input, registered read data
`timescale 1ns/1ps
module prev_sample_mem #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock
  input wire clk_i,
  // Write side
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [WIDTH-1:0] wr_data_i,
  // Read side
  input wire rd_en_i,
  input wire [AW-1:0] rd_addr_i,
  output reg [WIDTH-1:0] rd_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clk_i)
  begin
    if (wr_en_i)
      mem[wr_addr_i] <= wr_data_i;
    if (rd_en_i)
      rd_data_o <= mem[rd_addr_i];
  end
endmodule // prev_sample_mem

// file: low_power_heartbeat_relay.v
// Low-power limit checking and heartbeat frame relay for one chain monitor
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "low_power_monitoring_hb_regs.vh"
module low_power_heartbeat_relay #(
  parameter SAMPLE_W = 16,
  parameter CELLS = 16,
  parameter AUXES = 10,
  parameter [31:0] START_DELAY_CYC = `START_DELAY_US * `CLK_MHZ,
  parameter [31:0] MIN_RELAY_CYC = `MIN_RELAY_US * `CLK_MHZ,
  parameter [31:0] PERIOD_CYC = `PERIOD_US * `CLK_MHZ,
  parameter [15:0] HB_CMD_CODE = 16'h0123,
  parameter [15:0] CHECK_POLY = 16'h8005,
  parameter [15:0] CHECK_SEED = 16'h0010
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Register port
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  // Measurement stream
  output reg meas_req_o,
  input wire meas_valid_i,
  input wire meas_is_aux_i,
  input wire [3:0] meas_chan_i,
  input wire [SAMPLE_W-1:0] meas_value_i,
  input wire meas_done_i,
  input wire diag_fail_i,
  // Upstream heartbeat bytes
  input wire rx_valid_i,
  input wire rx_sof_i,
  input wire [7:0] rx_byte_i,
  // Downstream heartbeat bytes
  output wire tx_valid_o,
  output reg [7:0] tx_byte_o,
  output wire tx_last_o,
  input wire tx_ready_i
);
  localparam SLOTS = CELLS + AUXES;
  localparam AW = 5;
  localparam [31:0] AUX_BASE = CELLS;
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_WAIT = 5'b00010;
  localparam [4:0] ST_MEAS = 5'b00100;
  localparam [4:0] ST_HOLD = 5'b01000;
  localparam [4:0] ST_SEND = 5'b10000;

  reg [4:0] state;
  reg [1:0] ctrl;
  reg [7:0] chain_device_count_cfg;
  reg [15:0] cell_under_limit;
  reg [15:0] cell_over_limit;
  reg [15:0] cell_delta_limit;
  reg [15:0] aux_under_limit;
  reg [15:0] aux_over_limit;
  reg [15:0] aux_delta_limit;
  reg [CELLS-1:0] cell_mask;
  reg [AUXES-1:0] aux_mask;
  reg [7:0] monitor_fault_flags;
  reg [7:0] last_tx_count;
  reg en_d;
  reg [31:0] timer;
  reg [31:0] relay_timer;
  reg done_seen;
  reg [7:0] up_count;
  reg [7:0] up_flags;
  reg [63:0] rx_shift;
  reg [2:0] rx_idx;
  reg [63:0] tx_frame;
  reg [2:0] tx_idx;
  reg s1_valid;
  reg s1_aux;
  reg [AW-1:0] s1_slot;
  reg [SAMPLE_W-1:0] s1_value;
  reg [SLOTS-1:0] prev_ok;
  wire [SAMPLE_W-1:0] prev_value;

  wire enabled = ctrl[`CTRL_EN_BIT];
  wire manager = ctrl[`CTRL_MGR_BIT];
  wire enable_rise = enabled & ~en_d;
  wire [AW-1:0] in_slot = meas_is_aux_i ? (AUX_BASE[AW-1:0] + {1'b0, meas_chan_i}) :
                                           {1'b0, meas_chan_i};
  wire in_masked = meas_is_aux_i ? aux_mask[meas_chan_i] : cell_mask[meas_chan_i];
  wire take_sample = (state == ST_MEAS) & meas_valid_i & ~in_masked;

  function [15:0] check16;
    input [15:0] data;
    integer i;
    reg [15:0] crc;
    begin
      crc = CHECK_SEED;
      for (i = 15; i >= 0; i = i - 1)
        crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ data[i]) ? CHECK_POLY : 16'h0000);
      check16 = crc;
    end
  endfunction

  prev_sample_mem #(
    .WIDTH(SAMPLE_W),
    .DEPTH(32),
    .AW(AW)
  ) u_prev (
    .clk_i(clk_i),
    .wr_en_i(s1_valid),
    .wr_addr_i(s1_slot),
    .wr_data_i(s1_value),
    .rd_en_i(take_sample),
    .rd_addr_i(in_slot),
    .rd_data_o(prev_value)
  );

  // Limit selection and comparisons on the staged sample
  wire [15:0] lim_under = s1_aux ? aux_under_limit : cell_under_limit;
  wire [15:0] lim_over = s1_aux ? aux_over_limit : cell_over_limit;
  wire [15:0] lim_delta = s1_aux ? aux_delta_limit : cell_delta_limit;
  wire has_prev = prev_ok[s1_slot];
  wire hit_under = s1_value < lim_under;
  wire hit_over = s1_value > lim_over;
  wire hit_rise = has_prev & (s1_value > prev_value) &
                  ((s1_value - prev_value) > lim_delta);
  wire hit_fall = has_prev & (prev_value > s1_value) &
                  ((prev_value - s1_value) > lim_delta);
  wire [3:0] hits = {hit_rise, hit_fall, hit_over, hit_under};
  wire [7:0] sample_flags = s1_valid ? (s1_aux ? {hits, 4'h0} : {4'h0, hits}) : 8'h00;

  // Sample pipeline and per-input history validity
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_valid <= 1'b0;
      s1_aux <= 1'b0;
      s1_slot <= 5'h00;
      s1_value <= 16'h0000;
    end
    else
    begin
      s1_valid <= take_sample;
      s1_aux <= meas_is_aux_i;
      s1_slot <= in_slot;
      s1_value <= meas_value_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < SLOTS; g = g + 1)
    begin : g_hist
      always @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
          prev_ok[g] <= 1'b0;
        else if (enable_rise)
          prev_ok[g] <= 1'b0;
        else if (s1_valid && s1_slot == g)
          prev_ok[g] <= 1'b1;
      end
    end
  endgenerate

  // Sticky flags: hardware set wins over a software clear in the same cycle
  wire flag_clear = wr_i & (addr_i == `ADDR_FLAGS) & (wdata_i == `CLEAR_KEY);
  wire diag_hit = (state == ST_MEAS) & diag_fail_i;
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      monitor_fault_flags <= `FLAGS_NONE;
    else if (diag_hit)
      monitor_fault_flags <= `FLAGS_ALL;
    else
      monitor_fault_flags <= (flag_clear ? `FLAGS_NONE : monitor_fault_flags) |
                             sample_flags;
  end

  // Register writes
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl <= 2'h0;
      chain_device_count_cfg <= `NDEV_RST;
      cell_under_limit <= `UV_RST;
      cell_over_limit <= `OV_RST;
      cell_delta_limit <= `DV_RST;
      aux_under_limit <= `UV_RST;
      aux_over_limit <= `OV_RST;
      aux_delta_limit <= `DV_RST;
      cell_mask <= {CELLS{1'b0}};
      aux_mask <= {AUXES{1'b0}};
    end
    else if (wr_i)
    begin
      case (addr_i)
        `ADDR_CTRL: ctrl <= wdata_i[1:0];
        `ADDR_NDEV: chain_device_count_cfg <= wdata_i[7:0];
        `ADDR_CELL_UV: cell_under_limit <= wdata_i;
        `ADDR_CELL_OV: cell_over_limit <= wdata_i;
        `ADDR_CELL_DV: cell_delta_limit <= wdata_i;
        `ADDR_AUX_UV: aux_under_limit <= wdata_i;
        `ADDR_AUX_OV: aux_over_limit <= wdata_i;
        `ADDR_AUX_DV: aux_delta_limit <= wdata_i;
        `ADDR_CELL_MASK: cell_mask <= wdata_i[CELLS-1:0];
        `ADDR_AUX_MASK: aux_mask <= wdata_i[AUXES-1:0];
        default: ;
      endcase
    end
  end

  // Register reads, data valid only in the cycle after the strobe
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 16'h0000;
    else if (!rd_i)
      rdata_o <= 16'h0000;
    else
    begin
      case (addr_i)
        `ADDR_CTRL: rdata_o <= {14'h0000, ctrl};
        `ADDR_NDEV: rdata_o <= {8'h00, chain_device_count_cfg};
        `ADDR_CELL_UV: rdata_o <= cell_under_limit;
        `ADDR_CELL_OV: rdata_o <= cell_over_limit;
        `ADDR_CELL_DV: rdata_o <= cell_delta_limit;
        `ADDR_AUX_UV: rdata_o <= aux_under_limit;
        `ADDR_AUX_OV: rdata_o <= aux_over_limit;
        `ADDR_AUX_DV: rdata_o <= aux_delta_limit;
        `ADDR_CELL_MASK: rdata_o <= {{(16-CELLS){1'b0}}, cell_mask};
        `ADDR_AUX_MASK: rdata_o <= {{(16-AUXES){1'b0}}, aux_mask};
        `ADDR_FLAGS: rdata_o <= {8'h00, monitor_fault_flags};
        `ADDR_STATUS: rdata_o <= {3'h0, state, last_tx_count};
        default: rdata_o <= 16'h0000;
      endcase
    end
  end

  // Upstream frame capture and check-code test
  wire [63:0] rx_full = {rx_shift[55:0], rx_byte_i};
  wire rx_end = rx_valid_i & (rx_sof_i ? 1'b0 : (rx_idx == `LAST_BYTE));
  wire rx_cmd_ok = (rx_full[63:48] == HB_CMD_CODE) &
                   (rx_full[47:32] == check16(rx_full[63:48]));
  wire rx_pay_ok = rx_full[15:0] == check16(rx_full[31:16]);
  wire rx_good = rx_end & rx_cmd_ok & rx_pay_ok;
  wire rx_take = rx_good & enabled & ~manager & (state == ST_IDLE);

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_shift <= 64'h0000_0000_0000_0000;
      rx_idx <= 3'h0;
      up_count <= 8'h00;
      up_flags <= 8'h00;
    end
    else
    begin
      if (rx_valid_i)
      begin
        rx_shift <= rx_full;
        rx_idx <= rx_sof_i ? 3'h1 : rx_idx + 3'h1;
      end
      if (rx_take)
      begin
        up_count <= rx_full[31:24];
        up_flags <= rx_full[23:16];
      end
    end
  end

  // Outgoing frame contents
  wire [7:0] base_count = manager ? chain_device_count_cfg : up_count;
  wire clean = (monitor_fault_flags == `FLAGS_NONE);
  wire [7:0] out_count = clean ? base_count - 8'h01 : base_count;
  wire [7:0] out_flags = (manager ? `FLAGS_NONE : up_flags) | monitor_fault_flags;
  wire [15:0] out_payload = {out_count, out_flags};
  wire [63:0] out_frame = {HB_CMD_CODE, check16(HB_CMD_CODE),
                           out_payload, check16(out_payload)};
  wire meas_finished = done_seen & ~s1_valid & ~take_sample;

  assign tx_valid_o = (state == ST_SEND);
  assign tx_last_o = tx_valid_o & (tx_idx == `LAST_BYTE);

  // Sequencing
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      en_d <= 1'b0;
      timer <= 32'h0000_0000;
      relay_timer <= 32'h0000_0000;
      done_seen <= 1'b0;
      meas_req_o <= 1'b0;
      tx_frame <= 64'h0000_0000_0000_0000;
      tx_byte_o <= 8'h00;
      tx_idx <= 3'h0;
      last_tx_count <= 8'h00;
    end
    else
    begin
      en_d <= enabled;
      meas_req_o <= 1'b0;
      if (relay_timer != 32'h0000_0000)
        relay_timer <= relay_timer - 32'h0000_0001;
      if (meas_done_i && state == ST_MEAS)
        done_seen <= 1'b1;
      if (!enabled)
        state <= ST_IDLE;
      else
      begin
        case (state)
          ST_IDLE:
          begin
            if (enable_rise && manager)
            begin
              timer <= START_DELAY_CYC;
              state <= ST_WAIT;
            end
            else if (rx_take)
            begin
              relay_timer <= MIN_RELAY_CYC;
              done_seen <= 1'b0;
              meas_req_o <= 1'b1;
              state <= ST_MEAS;
            end
          end
          ST_WAIT:
          begin
            if (timer <= 32'h0000_0001)
            begin
              done_seen <= 1'b0;
              meas_req_o <= 1'b1;
              state <= ST_MEAS;
            end
            else
              timer <= timer - 32'h0000_0001;
          end
          ST_MEAS:
          begin
            if (meas_finished)
              state <= ST_HOLD;
          end
          ST_HOLD:
          begin
            // Hold keeps a fast relay from outrunning the downstream wake-up
            if (relay_timer == 32'h0000_0000 || manager)
            begin
              tx_frame <= {out_frame[55:0], 8'h00};
              tx_byte_o <= out_frame[63:56];
              tx_idx <= 3'h0;
              last_tx_count <= out_count;
              state <= ST_SEND;
            end
          end
          ST_SEND:
          begin
            if (tx_ready_i)
            begin
              tx_byte_o <= tx_frame[63:56];
              tx_frame <= {tx_frame[55:0], 8'h00};
              tx_idx <= tx_idx + 3'h1;
              if (tx_idx == `LAST_BYTE)
              begin
                timer <= PERIOD_CYC;
                state <= manager ? ST_WAIT : ST_IDLE;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // low_power_heartbeat_relay

// file: low_power_monitoring_hb_monitor.sv
// Port checker for the heartbeat relay
`timescale 1ns/1ps
module heartbeat_port_monitor (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Register port
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [15:0] rdata_o,
  // Measurement and frame side
  input wire meas_req_o,
  input wire meas_done_i,
  input wire tx_valid_o,
  input wire [7:0] tx_byte_o,
  input wire tx_last_o,
  input wire tx_ready_i
);
  reg [2:0] idx;
  reg measured;
  wire take = tx_valid_o && tx_ready_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      idx <= 3'h0;
      measured <= 1'b0;
    end
    else
    begin
      idx <= idx + {2'h0, take};
      measured <= meas_done_i || (measured && !(take && tx_last_o));
    end
  sequence mgr_on;
    wr_i && addr_i == 4'h0 && wdata_i[1:0] == 2'h3;
  endsequence
  sequence quiet8;
    !meas_req_o [*8];
  endsequence
  a_read_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside read");
  a_unmapped_read: assert property (rd_i && addr_i > 4'hB |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_last_valid: assert property (tx_last_o |-> tx_valid_o)
    else $error("last without valid");
  a_byte_held: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
    else $error("byte dropped while stalled");
  a_frame_length: assert property (take |-> tx_last_o == (idx == 3'h7))
    else $error("frame not eight bytes");
  a_req_pulse: assert property (meas_req_o |=> !meas_req_o)
    else $error("request longer than one cycle");
  a_req_quiet_tx: assert property (tx_valid_o |-> !meas_req_o)
    else $error("measuring while sending");
  a_regen_after_meas: assert property ($rose(tx_valid_o) |-> measured)
    else $error("frame sent before measuring");
  a_start_quiet: assert property (mgr_on |=> quiet8)
    else $error("manager started early");
  a_start_bound: assert property (mgr_on |-> ##[1:120] meas_req_o)
    else $error("manager start missing");
endmodule // heartbeat_port_monitor
bind low_power_heartbeat_relay heartbeat_port_monitor mon (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .meas_req_o(meas_req_o), .meas_done_i(meas_done_i),
  .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i)
);

// file: chain_neighbor_model.sv
// Neighbouring chain devices: upstream frame source and downstream frame sink
`timescale 1ns/1ps
module chain_neighbor_model (
  // Clock and stall mode
  input wire clk_i,
  input wire slow_i,
  // Upstream frame bytes
  output reg hb_valid_o = 1'b0,
  output reg hb_sof_o = 1'b0,
  output reg [7:0] hb_byte_o = 8'h00,
  // Downstream frame bytes
  input wire frame_valid_i,
  input wire [7:0] frame_byte_i,
  input wire frame_last_i,
  output reg ready_o = 1'b0
);
  reg [7:0] q[$];
  reg [7:0] got[0:7];
  integer got_n = 0;
  integer last_at = -1;
  reg chain_pass = 1'b0;
  function [15:0] check16(input [15:0] d);
    integer i;
    begin
      check16 = 16'h0010;
      for (i = 15; i >= 0; i = i - 1)
        check16 = {check16[14:0], 1'b0} ^ ((check16[15] ^ d[i]) ? 16'h8005 : 16'h0000);
    end
  endfunction
  task send_frame(input [15:0] cmd, input [7:0] cnt, input [7:0] flg, input bad);
    reg [15:0] cc, pc;
    begin
      cc = check16(cmd);
      pc = check16({cnt, flg}) ^ {15'h0000, bad};
      q = {cmd[15:8], cmd[7:0], cc[15:8], cc[7:0], cnt, flg, pc[15:8], pc[7:0]};
      wait (q.size() == 0);
    end
  endtask
  always @(posedge clk_i)
  begin
    hb_valid_o <= q.size() != 0;
    hb_sof_o <= q.size() == 8;
    // Idle line toggles so a stale byte is never mistaken for data
    if (q.size() != 0)
      hb_byte_o <= q.pop_front();
    else
      hb_byte_o <= ~hb_byte_o;
    ready_o <= slow_i ? ~ready_o : 1'b1;
    if (frame_valid_i && ready_o)
    begin
      got[got_n[2:0]] <= frame_byte_i;
      got_n <= got_n + 1;
      if (frame_last_i)
      begin
        last_at <= got_n;
        chain_pass <= got[4] == 8'h42 && got[5] == 8'h00;
      end
    end
  end
endmodule // chain_neighbor_model

// file: tb_top.sv
// Self-checking bench for the heartbeat relay
`timescale 1ns/1ps
module tb_top;
  localparam [15:0] CMD = 16'h0123;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [3:0] addr_i = 4'h0;
  reg [15:0] wdata_i = 16'h0000;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg mv = 1'b0;
  reg maux = 1'b0;
  reg [3:0] mch = 4'h0;
  reg [15:0] mval = 16'h0000;
  reg mdone = 1'b0;
  reg diag = 1'b0;
  reg slow = 1'b0;
  wire [15:0] rdata;
  wire req, rxv, rxs, txv, txl, txr;
  wire [7:0] rxb, txb;
  integer seed = 69199;
  integer bad_count = 0;
  integer total_checks = 0;
  integer flags_m = 0;
  integer lim[0:9];
  integer prev_m[0:31];
  integer seen_m[0:31];
  integer sq[$];
  integer i, k;
  always #2.5 clk_i = ~clk_i;
  low_power_heartbeat_relay #(
    .START_DELAY_CYC(32'h0000_0032), .MIN_RELAY_CYC(32'h0000_0014),
    .PERIOD_CYC(32'h0000_00C8), .HB_CMD_CODE(CMD)
  ) dut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata), .meas_req_o(req), .meas_valid_i(mv), .meas_is_aux_i(maux),
    .meas_chan_i(mch), .meas_value_i(mval), .meas_done_i(mdone), .diag_fail_i(diag),
    .rx_valid_i(rxv), .rx_sof_i(rxs), .rx_byte_i(rxb),
    .tx_valid_o(txv), .tx_byte_o(txb), .tx_last_o(txl), .tx_ready_i(txr)
  );
  chain_neighbor_model peer (
    .clk_i(clk_i), .slow_i(slow), .hb_valid_o(rxv), .hb_sof_o(rxs), .hb_byte_o(rxb),
    .frame_valid_i(txv), .frame_byte_i(txb), .frame_last_i(txl), .ready_o(txr)
  );
  task print_verdict;
    begin
      if (bad_count == 0 && total_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task check(input [15:0] seen, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      if (a < 4'hA)
        lim[a] = d;
    end
  endtask
  task rd(input [3:0] a, input [15:0] exp);
    begin
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 check(rdata, exp);
    end
  endtask
  task put(input integer a, input integer c, input integer v);
    sq.push_back((a << 20) | (c << 16) | v);
  endtask
  task pass(input integer d);
    integer a, c, v, b, n;
    begin
      k = 0;
      while (req !== 1'b1 && k < 300)
      begin
        @(posedge clk_i);
        #1 k = k + 1;
      end
      check(k < 300, 16'h0001);
      diag <= d[0];
      while (sq.size() > 0)
      begin
        v = sq.pop_front();
        a = v >> 20;
        c = (v >> 16) & 15;
        v = v & 65535;
        @(posedge clk_i);
        mv <= 1'b1;
        maux <= a[0];
        mch <= c[3:0];
        mval <= v[15:0];
        b = a * 4;
        n = a * 16 + c;
        // Masked inputs leave both flags and delta history alone
        if (!lim[8 + a][c])
        begin
          if (v < lim[2 + a * 3])
            flags_m = flags_m | (1 << b);
          if (v > lim[3 + a * 3])
            flags_m = flags_m | (2 << b);
          if (seen_m[n] === 1 && prev_m[n] - v > lim[4 + a * 3])
            flags_m = flags_m | (4 << b);
          if (seen_m[n] === 1 && v - prev_m[n] > lim[4 + a * 3])
            flags_m = flags_m | (8 << b);
          prev_m[n] = v;
          seen_m[n] = 1;
        end
      end
      @(posedge clk_i);
      mv <= 1'b0;
      mdone <= 1'b1;
      @(posedge clk_i);
      mdone <= 1'b0;
      diag <= 1'b0;
      if (d)
        flags_m = 255;
    end
  endtask
  task expect_frame(input [7:0] cnt, input [7:0] up);
    reg [7:0] e[0:7];
    reg [15:0] cc, pc;
    begin
      k = 0;
      while (peer.got_n < 8 && k < 400)
      begin
        @(posedge clk_i);
        k = k + 1;
      end
      check(k < 400, 16'h0001);
      e[4] = flags_m != 0 ? cnt : cnt - 8'h01;
      e[5] = up | flags_m[7:0];
      cc = peer.check16(CMD);
      pc = peer.check16({e[4], e[5]});
      {e[0], e[1], e[2], e[3], e[6], e[7]} = {CMD, cc, pc};
      for (k = 0; k < 8; k = k + 1)
        check(peer.got[k], e[k]);
      check(peer.last_at, 16'h0007);
      check(peer.chain_pass, e[4] == 8'h42 && e[5] == 8'h00);
      peer.got_n = 0;
    end
  endtask
  initial
  begin
    lim[2] = 0;
    lim[3] = 65535;
    lim[4] = 65535;
    lim[5] = 0;
    lim[6] = 65535;
    lim[7] = 65535;
    lim[8] = 0;
    lim[9] = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 13; i = i + 1)
      rd(i, i == 1 ? 16'h0042 : i == 11 ? 16'h0100 :
            (i > 1 && i < 10) ? lim[i] : 16'h0000);
    // Delta limits stay untrippable until the delta pass
    wr(4'h2, 16'h01F4);
    wr(4'h3, 16'h07D0);
    wr(4'h5, 16'h01F4);
    wr(4'h6, 16'h07D0);
    wr(4'h9, 16'h0002);
    wr(4'h1, 16'h0048);
    wr(4'h0, 16'h0003);
    for (i = 0; i < 26; i = i + 1)
      put(i / 16, i % 16, 600 + $unsigned($random(seed)) % 1000);
    pass(0);
    expect_frame(8'h48, 8'h00);
    rd(4'hB, 16'h0247);
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h0001);
    for (i = 0; i < 32; i = i + 1)
      seen_m[i] = 0;
    wr(4'h4, 16'h0064);
    wr(4'h7, 16'h0064);
    peer.send_frame(CMD, 8'h43, 8'h00, 1'b0);
    put(0, 2, 16'h03E8);
    put(0, 3, 16'h03E8);
    put(1, 0, 16'h02BC);
    put(1, 2, 16'h03E8);
    pass(0);
    expect_frame(8'h43, 8'h00);
    slow = 1'b1;
    peer.send_frame(CMD, 8'h45, 8'h80, 1'b0);
    put(0, 2, 16'h04B0);
    put(0, 3, 16'h0352);
    put(0, 4, 16'h0064);
    put(1, 0, 16'h09C4);
    put(1, 1, 16'h0000);
    put(1, 2, 16'h0258);
    pass(0);
    expect_frame(8'h45, 8'h80);
    rd(4'hA, flags_m);
    peer.send_frame(CMD, 8'h45, 8'h00, 1'b1);
    k = 0;
    for (i = 0; i < 40; i = i + 1)
    begin
      @(posedge clk_i);
      #1 k = k + req;
    end
    check(k, 16'h0000);
    wr(4'hA, 16'h00FF);
    rd(4'hA, flags_m);
    wr(4'hA, 16'hFFFF);
    flags_m = 0;
    rd(4'hA, 16'h0000);
    peer.send_frame(CMD, 8'h44, 8'h00, 1'b0);
    put(0, 0, 16'h03E8);
    pass(1);
    expect_frame(8'h44, 8'h00);
    rd(4'hA, 16'h00FF);
    print_verdict;
  end
  initial
  begin
    #100000;
    bad_count = bad_count + 1;
    print_verdict;
  end
endmodule // tb_top
